/* File: timer_pkg.sv */
// Shared constants for the timer/counter block: addresses, fields, modes
package timer_pkg;
    // ==========================================
    // Special-function addresses
    localparam logic [7:0] ADDR_T0_LOW = 8'h8a;
    localparam logic [7:0] ADDR_T1_LOW = 8'h8b;
    localparam logic [7:0] ADDR_T0_HIGH = 8'h8c;
    localparam logic [7:0] ADDR_T1_HIGH = 8'h8d;
    localparam logic [7:0] ADDR_T2_CONTROL = 8'hc8;
    localparam logic [7:0] ADDR_T2_RELOAD_LOW = 8'hca;
    localparam logic [7:0] ADDR_T2_RELOAD_HIGH = 8'hcb;
    localparam logic [7:0] ADDR_T2_COUNT_LOW = 8'hcc;
    localparam logic [7:0] ADDR_T2_COUNT_HIGH = 8'hcd;

    // ==========================================
    // Timer 2 control field positions
    localparam int BIT_OVF = 7;
    localparam int BIT_EXT = 6;
    localparam int BIT_RCLK = 5;
    localparam int BIT_SERIAL_TX_CLOCK_SELECT = 4;
    localparam int BIT_EXEN = 3;
    localparam int BIT_RUN = 2;
    localparam int BIT_CNT = 1;
    localparam int BIT_CAP = 0;

    // ==========================================
    // Reset values and byte limits
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [7:0] BYTE_ALL_ONES = 8'hff;
    localparam logic [15:0] WORD_ALL_ONES = 16'hffff;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [7:0] BYTE_ONE = 8'h01;
    localparam logic [15:0] WORD_ONE = 16'h0001;

    // ==========================================
    // Timer 0/1 mode codes
    localparam logic [1:0] MODE_AUTORELOAD = 2'h2;
    localparam logic [1:0] MODE_SPLIT = 2'h3;

    // ==========================================
    // Pin order on the edge detector
    localparam int PIN_T0 = 0;
    localparam int PIN_T1 = 1;
    localparam int PIN_T2 = 2;
    localparam int PIN_TRIG = 3;
    localparam int PIN_COUNT = 4;
endpackage : timer_pkg

/* File: pin_fall_detect.sv */
// Two-flop synchroniser and falling-edge detector for external pins
`timescale 1ns/1ns
`default_nettype none
module pin_fall_detect #(
    parameter int WIDTH = 4
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [WIDTH-1:0] PIN,
    output logic [WIDTH-1:0] FALL
);
    // ==========================================
    // Per-pin chain
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_pin
            logic meta_q;
            logic sync_q;
            logic prev_q;
            // First stage feeds only the second; pins idle high after reset
            always_ff @(posedge CLK) begin
                if (!RST_N) begin
                    meta_q <= 1'b1;
                    sync_q <= 1'b1;
                    prev_q <= 1'b1;
                end else begin
                    meta_q <= PIN[g];
                    sync_q <= meta_q;
                    prev_q <= sync_q;
                end
            end
            // Edge from two settled samples
            assign FALL[g] = prev_q & ~sync_q; // [RL23]
        end
    endgenerate
endmodule : pin_fall_detect
`default_nettype wire

/* File: timer_block.sv */
// Timer 0/1 in modes 2 and 3 and timer 2 with capture, reload and baud outputs
`timescale 1ns/1ns
`default_nettype none
//
// Contract
// [RL1] Timer 0 mode 2: low byte counts, overflow sets flag and reloads from high.
// [RL2] Mode 2 reload never alters the high byte.
// [RL3] Timer 1 mode 3 holds its count as if its run bit were off.
// [RL4] Timer 0 mode 3: low byte uses timer 0 select, gate, run, pin, flag.
// [RL5] Timer 0 mode 3: high byte counts cycles on timer 1 run, sets timer 1 flag.
// [RL6] Then timer 1 starts/stops by mode, still gives baud ticks, no flag; here timer 1 also needs TIMER1_RUN_BIT set to count.
// [RL7] Timer 2 overflow flag set on overflow, software clears, never in baud mode.
// [RL8] External flag set by enabled trigger capture or reload; software clears.
// [RL9] Bit 5 picks timer 2 overflow for receive clock, else timer 1.
// [RL10] Bit 4 picks timer 2 overflow for transmit clock, else timer 1.
// [RL11] Bit 3 enables trigger edges when not in baud mode, else ignored.
// [RL12] Bit 2 runs timer 2 when set, halts it when clear.
// [RL13] Bit 1 counts count-pin falls when set, core cycles when clear.
// [RL14] Bit 0 selects capture on trigger; clear gives reload on overflow or trigger.
// [RL15] Baud mode ignores bit 0 and forces reload on each overflow.
// [RL16] Timer 2 count bytes at CDH and CCH, reset zero.
// [RL17] Capture/reload bytes at CBH and CAH serve capture and reload.
// [RL18] Timer 2 control at C8H, reset zero, bit addressable.
// [RL19] Timer 0 counts only with run set and gate clear or pin high.
// [RL20] Setting a run bit leaves the count registers alone.
// [RL21] Autoreload loads timer 2 from the capture/reload pair.
// [RL22] Capture copies timer 2 low and high into capture/reload bytes.
// [RL23] External count and trigger pins are synchronised and fall-detected.
module timer_block (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [7:0] SFR_ADDR,
    input wire logic [7:0] SFR_WDATA,
    input wire logic SFR_WE,
    input wire logic SFR_BIT_WE,
    input wire logic [2:0] SFR_BIT_IDX,
    input wire logic SFR_RE,
    output logic [7:0] SFR_RDATA,
    output logic SFR_HIT,
    input wire logic [1:0] TIMER0_MODE,
    input wire logic TIMER0_COUNTER_SELECT,
    input wire logic TIMER0_GATE,
    input wire logic TIMER0_RUN_BIT,
    input wire logic [1:0] TIMER1_MODE,
    input wire logic TIMER1_COUNTER_SELECT,
    input wire logic TIMER1_GATE,
    input wire logic TIMER1_RUN_BIT,
    input wire logic EXTERNAL_INTERRUPT_PIN_ZERO,
    input wire logic EXTERNAL_INTERRUPT_PIN_ONE,
    input wire logic TIMER0_COUNT_PIN,
    input wire logic TIMER1_COUNT_PIN,
    input wire logic TIMER2_COUNT_PIN,
    input wire logic EXTERNAL_TRIGGER_INPUT,
    input wire logic TIMER0_FLAG_CLEAR,
    input wire logic TIMER1_FLAG_CLEAR,
    output logic TIMER0_OVERFLOW_FLAG,
    output logic TIMER1_OVERFLOW_FLAG,
    output logic TIMER2_OVERFLOW_FLAG,
    output logic TIMER2_EXTERNAL_FLAG,
    output logic RX_BAUD_TICK,
    output logic TX_BAUD_TICK
);
    // ==========================================
    // Pin edges
    // Pins are asynchronous, so every edge decision waits for the two sync stages;
    // an event therefore lands three cycles after the pin falls
    logic [timer_pkg::PIN_COUNT-1:0] pin_fall;

    pin_fall_detect #(
        .WIDTH(timer_pkg::PIN_COUNT)
    ) u_pins (
        .CLK(CLK),
        .RST_N(RST_N),
        .PIN({EXTERNAL_TRIGGER_INPUT, TIMER2_COUNT_PIN, TIMER1_COUNT_PIN, TIMER0_COUNT_PIN}),
        .FALL(pin_fall)
    );

    // ==========================================
    // State
    logic [7:0] t0_low_q, t0_low_d;
    logic [7:0] t0_high_q, t0_high_d;
    logic [7:0] t1_low_q, t1_low_d;
    logic [7:0] t1_high_q, t1_high_d;
    logic [7:0] t2_ctl_q, t2_ctl_d;
    logic [15:0] t2_count_q, t2_count_d;
    logic [15:0] t2_reload_q, t2_reload_d;
    logic tf0_q, tf0_d;
    logic tf1_q, tf1_d;
    logic rx_tick_q, tx_tick_q;
    logic [7:0] rdata_q, rdata_d;

    // ==========================================
    // Register decode
    wire wr_any = SFR_WE | SFR_BIT_WE;
    wire wr_t0l = wr_any && SFR_ADDR == timer_pkg::ADDR_T0_LOW;
    wire wr_t0h = wr_any && SFR_ADDR == timer_pkg::ADDR_T0_HIGH;
    wire wr_t1l = wr_any && SFR_ADDR == timer_pkg::ADDR_T1_LOW;
    wire wr_t1h = wr_any && SFR_ADDR == timer_pkg::ADDR_T1_HIGH;
    wire wr_ctl = wr_any && SFR_ADDR == timer_pkg::ADDR_T2_CONTROL; // [RL18]
    wire wr_rl = wr_any && SFR_ADDR == timer_pkg::ADDR_T2_RELOAD_LOW; // [RL17]
    wire wr_rh = wr_any && SFR_ADDR == timer_pkg::ADDR_T2_RELOAD_HIGH; // [RL17]
    wire wr_cl = wr_any && SFR_ADDR == timer_pkg::ADDR_T2_COUNT_LOW; // [RL16]
    wire wr_ch = wr_any && SFR_ADDR == timer_pkg::ADDR_T2_COUNT_HIGH; // [RL16]

    // Bit writes act as read-modify-write on the control register only; other addresses take the whole SFR_WDATA byte
    wire [7:0] bit_mask = timer_pkg::BYTE_ONE << SFR_BIT_IDX;
    wire [7:0] bit_val = SFR_WDATA[0] ? bit_mask : timer_pkg::BYTE_RESET;

    // ==========================================
    // Timer 2 control fields
    wire t2_rclk = t2_ctl_q[timer_pkg::BIT_RCLK];
    wire t2_serial_tx_clock_select = t2_ctl_q[timer_pkg::BIT_SERIAL_TX_CLOCK_SELECT];
    wire t2_exen = t2_ctl_q[timer_pkg::BIT_EXEN];
    wire t2_run = t2_ctl_q[timer_pkg::BIT_RUN];
    wire t2_cnt = t2_ctl_q[timer_pkg::BIT_CNT];
    wire t2_cap = t2_ctl_q[timer_pkg::BIT_CAP];
    wire t2_baud = t2_rclk | t2_serial_tx_clock_select;

    // ==========================================
    // Timer 0 low byte, modes 2 and 3
    wire t0_split = TIMER0_MODE == timer_pkg::MODE_SPLIT;
    wire t0_autoreload = TIMER0_MODE == timer_pkg::MODE_AUTORELOAD;
    wire t0_gate_ok = ~TIMER0_GATE | EXTERNAL_INTERRUPT_PIN_ZERO; // [RL19]
    wire t0_event = TIMER0_COUNTER_SELECT ? pin_fall[timer_pkg::PIN_T0] : 1'b1; // [RL4]
    wire t0_low_inc = (t0_split | t0_autoreload) & TIMER0_RUN_BIT & t0_gate_ok & t0_event; // [RL19]
    wire t0_low_ovf = t0_low_inc && t0_low_q == timer_pkg::BYTE_ALL_ONES;
    wire [7:0] t0_low_wrap = t0_split ? timer_pkg::BYTE_RESET : t0_high_q; // [RL1]

    // Timer 0 high byte runs on core cycles under timer 1's run bit in split mode
    wire t0_high_inc = t0_split & TIMER1_RUN_BIT; // [RL5]
    wire t0_high_ovf = t0_high_inc && t0_high_q == timer_pkg::BYTE_ALL_ONES;

    // ==========================================
    // Timer 1 low byte, mode 2; mode 3 simply stops it
    wire t1_gate_ok = ~TIMER1_GATE | EXTERNAL_INTERRUPT_PIN_ONE;
    wire t1_event = TIMER1_COUNTER_SELECT ? pin_fall[timer_pkg::PIN_T1] : 1'b1;
    wire t1_autoreload = TIMER1_MODE == timer_pkg::MODE_AUTORELOAD; // [RL3] [RL6]
    wire t1_low_inc = t1_autoreload & TIMER1_RUN_BIT & t1_gate_ok & t1_event;
    wire t1_ovf = t1_low_inc && t1_low_q == timer_pkg::BYTE_ALL_ONES;

    // Timer 1 flag source moves to timer 0 high byte in split mode
    wire tf1_set = t0_split ? t0_high_ovf : t1_ovf; // [RL5] [RL6]

    // Timer 1 high byte is the mode 2 reload value; only software changes it
    assign t1_high_d = wr_t1h ? SFR_WDATA : t1_high_q;

    // ==========================================
    // Timer 2 counting and events
    wire t2_event = t2_cnt ? pin_fall[timer_pkg::PIN_T2] : 1'b1; // [RL13]
    wire t2_inc = t2_run & t2_event; // [RL12]
    // Overflow is judged on the count before the increment, so ffff is the last value
    wire t2_ovf = t2_inc && t2_count_q == timer_pkg::WORD_ALL_ONES;
    // Trigger edges are dropped while timer 2 clocks the serial port
    wire trig_ok = t2_exen & ~t2_baud & pin_fall[timer_pkg::PIN_TRIG]; // [RL11]
    // Capture mode lets an overflow wrap to zero; only reload modes load the pair
    wire do_capture = trig_ok & t2_cap; // [RL14]
    wire reload_mode = t2_baud | ~t2_cap; // [RL15]
    wire do_reload = reload_mode & (t2_ovf | trig_ok); // [RL14] [RL15] [RL21]
    wire tf2_set = t2_ovf & ~t2_baud; // [RL7]
    wire timer2_external_flag_set = trig_ok; // [RL8]

    // ==========================================
    // Next values for the 8-bit timers; a software write wins over counting
    always_comb begin
        t0_low_d = t0_low_q;
        if (wr_t0l) begin
            t0_low_d = SFR_WDATA;
        end else if (t0_low_ovf) begin
            t0_low_d = t0_low_wrap; // [RL1]
        end else if (t0_low_inc) begin
            t0_low_d = t0_low_q + timer_pkg::BYTE_ONE;
        end
        // High byte changes only by software or split-mode counting
        t0_high_d = t0_high_q; // [RL2]
        if (wr_t0h) begin
            t0_high_d = SFR_WDATA;
        end else if (t0_high_inc) begin
            t0_high_d = t0_high_q + timer_pkg::BYTE_ONE; // [RL5]
        end
        // Timer 1 reload comes from its high byte, exactly as for timer 0
        t1_low_d = t1_low_q;
        if (wr_t1l) begin
            t1_low_d = SFR_WDATA;
        end else if (t1_ovf) begin
            t1_low_d = t1_high_q;
        end else if (t1_low_inc) begin
            t1_low_d = t1_low_q + timer_pkg::BYTE_ONE;
        end
    end

    // Flags: hardware set wins over a clear in the same cycle, so an overflow
    // landing on the clear pulse is never lost; the handler simply sees it again
    assign tf0_d = t0_low_ovf | (tf0_q & ~TIMER0_FLAG_CLEAR); // [RL1] [RL4]
    assign tf1_d = tf1_set | (tf1_q & ~TIMER1_FLAG_CLEAR); // [RL5]

    // ==========================================
    // Timer 2 control, count and capture/reload next values
    always_comb begin
        t2_ctl_d = t2_ctl_q;
        if (wr_ctl) begin
            t2_ctl_d = SFR_BIT_WE ? ((t2_ctl_q & ~bit_mask) | bit_val) : SFR_WDATA; // [RL18]
        end
        if (tf2_set) begin
            t2_ctl_d[timer_pkg::BIT_OVF] = 1'b1; // [RL7]
        end
        if (timer2_external_flag_set) begin
            t2_ctl_d[timer_pkg::BIT_EXT] = 1'b1; // [RL8]
        end
        // A software byte write lands after counting so it wins for that byte only
        t2_count_d = t2_count_q;
        if (do_reload) begin
            t2_count_d = t2_reload_q; // [RL21]
        end else if (t2_inc) begin
            t2_count_d = t2_count_q + timer_pkg::WORD_ONE;
        end
        if (wr_cl) begin
            t2_count_d[7:0] = SFR_WDATA;
        end
        if (wr_ch) begin
            t2_count_d[15:8] = SFR_WDATA;
        end
        // Software writes to the pair override a capture landing in the same cycle
        t2_reload_d = t2_reload_q;
        if (do_capture) begin
            t2_reload_d = t2_count_q; // [RL22]
        end
        if (wr_rl) begin
            t2_reload_d[7:0] = SFR_WDATA;
        end
        if (wr_rh) begin
            t2_reload_d[15:8] = SFR_WDATA;
        end
    end

    // ==========================================
    // Read mux; unmapped addresses read zero and drop SFR_HIT
    // Read data is captured on the strobe and then held, so a late look still sees it
    always_comb begin
        SFR_HIT = 1'b1;
        rdata_d = timer_pkg::BYTE_RESET;
        unique case (SFR_ADDR)
            timer_pkg::ADDR_T0_LOW: rdata_d = t0_low_q;
            timer_pkg::ADDR_T0_HIGH: rdata_d = t0_high_q;
            timer_pkg::ADDR_T1_LOW: rdata_d = t1_low_q;
            timer_pkg::ADDR_T1_HIGH: rdata_d = t1_high_q;
            timer_pkg::ADDR_T2_CONTROL: rdata_d = t2_ctl_q;
            timer_pkg::ADDR_T2_RELOAD_LOW: rdata_d = t2_reload_q[7:0];
            timer_pkg::ADDR_T2_RELOAD_HIGH: rdata_d = t2_reload_q[15:8];
            timer_pkg::ADDR_T2_COUNT_LOW: rdata_d = t2_count_q[7:0];
            timer_pkg::ADDR_T2_COUNT_HIGH: rdata_d = t2_count_q[15:8];
            default: SFR_HIT = 1'b0;
        endcase
    end

    // ==========================================
    // Registers; run bits are never touched here, so counts survive a start
    // Synchronous reset only: the core reset is already aligned to this clock
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            t0_low_q <= timer_pkg::BYTE_RESET;
            t0_high_q <= timer_pkg::BYTE_RESET;
            t1_low_q <= timer_pkg::BYTE_RESET;
            t1_high_q <= timer_pkg::BYTE_RESET;
            t2_ctl_q <= timer_pkg::BYTE_RESET; // [RL18]
            t2_count_q <= timer_pkg::WORD_RESET; // [RL16]
            t2_reload_q <= timer_pkg::WORD_RESET; // [RL17]
            tf0_q <= 1'b0;
            tf1_q <= 1'b0;
        end else begin
            t0_low_q <= t0_low_d; // [RL20]
            t0_high_q <= t0_high_d;
            t1_low_q <= t1_low_d;
            t1_high_q <= t1_high_d;
            t2_ctl_q <= t2_ctl_d;
            t2_count_q <= t2_count_d; // [RL20]
            t2_reload_q <= t2_reload_d;
            tf0_q <= tf0_d;
            tf1_q <= tf1_d;
        end
    end

    // Read data and baud ticks registered; ticks lag the overflow by one cycle
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            rdata_q <= timer_pkg::BYTE_RESET;
            rx_tick_q <= 1'b0;
            tx_tick_q <= 1'b0;
        end else begin
            rdata_q <= SFR_RE ? rdata_d : rdata_q;
            rx_tick_q <= t2_rclk ? t2_ovf : t1_ovf; // [RL9]
            tx_tick_q <= t2_serial_tx_clock_select ? t2_ovf : t1_ovf; // [RL10] [RL6]
        end
    end

    // ==========================================
    // Outputs
    assign SFR_RDATA = rdata_q;
    assign TIMER0_OVERFLOW_FLAG = tf0_q;
    assign TIMER1_OVERFLOW_FLAG = tf1_q;
    assign TIMER2_OVERFLOW_FLAG = t2_ctl_q[timer_pkg::BIT_OVF];
    assign TIMER2_EXTERNAL_FLAG = t2_ctl_q[timer_pkg::BIT_EXT];
    assign RX_BAUD_TICK = rx_tick_q;
    assign TX_BAUD_TICK = tx_tick_q;
endmodule : timer_block
`default_nettype wire

/* File: timer_monitor.sv */
// Port-level checker for the timer block, bound to every instance
`timescale 1ns/1ns
`default_nettype none
module timer_monitor (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [7:0] SFR_ADDR,
    input wire logic [7:0] SFR_WDATA,
    input wire logic SFR_WE,
    input wire logic SFR_BIT_WE,
    input wire logic [2:0] SFR_BIT_IDX,
    input wire logic SFR_RE,
    input wire logic [7:0] SFR_RDATA,
    input wire logic SFR_HIT,
    input wire logic [1:0] TIMER0_MODE,
    input wire logic TIMER0_GATE,
    input wire logic TIMER0_RUN_BIT,
    input wire logic TIMER0_FLAG_CLEAR,
    input wire logic EXTERNAL_INTERRUPT_PIN_ZERO,
    input wire logic TIMER0_OVERFLOW_FLAG,
    input wire logic TIMER2_OVERFLOW_FLAG,
    input wire logic TIMER2_EXTERNAL_FLAG
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    // ==========================================
    // Shadow of the control bits that only software changes
    logic [7:0] ctl_q;
    logic [7:0] ctl_d;
    wire ctl_wr = (SFR_WE | SFR_BIT_WE) && SFR_ADDR == timer_pkg::ADDR_T2_CONTROL;
    assign ctl_d = SFR_WE ? SFR_WDATA : (ctl_q & ~(8'h01 << SFR_BIT_IDX))
        | ({7'h00, SFR_WDATA[0]} << SFR_BIT_IDX);
    always_ff @(posedge CLK) begin
        ctl_q <= !RST_N ? 8'h00 : (ctl_wr ? ctl_d : ctl_q);
    end
    // ==========================================
    // Map, read path and flag causes
    map_hit_a: assert property (SFR_HIT == (SFR_ADDR inside
        {8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'hc8, [8'hca:8'hcd]})) else $error("address map wrong");
    unmapped_read_a: assert property (SFR_RE && !SFR_HIT |=> SFR_RDATA == 8'h00)
        else $error("unmapped read not zero");
    control_read_a: assert property (SFR_RE && SFR_ADDR == 8'hc8 |=> SFR_RDATA ==
        {$past(TIMER2_OVERFLOW_FLAG), $past(TIMER2_EXTERNAL_FLAG), $past(ctl_q[5:0])})
        else $error("control read wrong");
    overflow_cause_a: assert property ($rose(TIMER2_OVERFLOW_FLAG) && !$past(ctl_wr)
        |-> $past(ctl_q[5:4]) == 2'h0) else $error("overflow flag set in baud mode");
    overflow_clear_a: assert property ($fell(TIMER2_OVERFLOW_FLAG) |-> $past(ctl_wr))
        else $error("overflow flag cleared by hardware");
    ext_cause_a: assert property ($rose(TIMER2_EXTERNAL_FLAG) && !$past(ctl_wr)
        |-> $past(ctl_q[3]) && $past(ctl_q[5:4]) == 2'h0) else $error("external flag cause");
    ext_clear_a: assert property ($fell(TIMER2_EXTERNAL_FLAG) |-> $past(ctl_wr))
        else $error("external flag cleared by hardware");
    timer0_gate_a: assert property ($rose(TIMER0_OVERFLOW_FLAG) |-> $past(TIMER0_RUN_BIT)
        && $past(TIMER0_MODE[1]) && (!$past(TIMER0_GATE) || $past(EXTERNAL_INTERRUPT_PIN_ZERO)))
        else $error("timer 0 counted while gated");
    timer0_clear_a: assert property ($fell(TIMER0_OVERFLOW_FLAG) |-> $past(TIMER0_FLAG_CLEAR))
        else $error("timer 0 flag lost");
endmodule : timer_monitor
bind timer_block timer_monitor mon (.*);
`default_nettype wire

/* File: pin_model.sv */
// Model of the external pins and the serial port beside the timer block
`timescale 1ns/1ns
`default_nettype none
module pin_model (
    input wire logic CLK,
    input wire logic RX_BAUD_TICK,
    input wire logic TX_BAUD_TICK,
    output logic [3:0] PIN
);
    int rx_n;
    int tx_n;
    // Pins idle high, as a pulled-up port line would
    initial begin
        PIN = 4'hf;
        rx_n = 0;
        tx_n = 0;
    end
    // Serial side takes one baud clock per tick
    always @(posedge CLK) begin
        if (RX_BAUD_TICK) rx_n <= rx_n + 1;
        if (TX_BAUD_TICK) tx_n <= tx_n + 1;
    end
    // Three cycles low and high, longer than the synchroniser needs
    task automatic fall(input int idx);
        @(negedge CLK);
        PIN[idx] = 1'b0;
        repeat (3) @(negedge CLK);
        PIN[idx] = 1'b1;
        repeat (3) @(negedge CLK);
    endtask : fall
endmodule : pin_model
`default_nettype wire

/* File: testbench.sv */
// Self-checking testbench for the timer block
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic CLK, RST_N, we, bwe, re, hit, gate0, run0, run1, external_interrupt_pin_zero, clr0, clr1, sel0;
    logic tf0, tf1, tf2, timer2_external_flag, rxt, txt;
    logic [7:0] addr, wd, rdata;
    logic [2:0] bidx;
    logic [1:0] m0, m1;
    logic [3:0] pin;
    logic [7:0] t2a [6] = '{8'hc8, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'hc9};
    int error_cnt, checked;
    timer_block dut (.CLK(CLK), .RST_N(RST_N), .SFR_ADDR(addr), .SFR_WDATA(wd), .SFR_WE(we),
        .SFR_BIT_WE(bwe), .SFR_BIT_IDX(bidx), .SFR_RE(re), .SFR_RDATA(rdata), .SFR_HIT(hit),
        .TIMER0_MODE(m0), .TIMER0_COUNTER_SELECT(sel0), .TIMER0_GATE(gate0),
        .TIMER0_RUN_BIT(run0), .TIMER1_MODE(m1), .TIMER1_COUNTER_SELECT(1'b0),
        .TIMER1_GATE(1'b0), .TIMER1_RUN_BIT(run1), .EXTERNAL_INTERRUPT_PIN_ZERO(external_interrupt_pin_zero),
        .EXTERNAL_INTERRUPT_PIN_ONE(1'b1), .TIMER0_COUNT_PIN(pin[0]), .TIMER1_COUNT_PIN(pin[1]),
        .TIMER2_COUNT_PIN(pin[2]), .EXTERNAL_TRIGGER_INPUT(pin[3]), .TIMER0_FLAG_CLEAR(clr0),
        .TIMER1_FLAG_CLEAR(clr1), .TIMER0_OVERFLOW_FLAG(tf0), .TIMER1_OVERFLOW_FLAG(tf1),
        .TIMER2_OVERFLOW_FLAG(tf2), .TIMER2_EXTERNAL_FLAG(timer2_external_flag), .RX_BAUD_TICK(rxt),
        .TX_BAUD_TICK(txt));
    pin_model pins (.CLK(CLK), .RX_BAUD_TICK(rxt), .TX_BAUD_TICK(txt), .PIN(pin));
    // ==========================================
    // Clock, verdict and watchdog
    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end
    task automatic stop_test;
        $display("checked=%0d error_cnt=%0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test
    // Whole run is a few hundred cycles, so this only fires on a hang
    initial begin
        #50000;
        error_cnt++;
        stop_test();
    end
    // ==========================================
    // Register access, one idle cycle between transfers
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge CLK);
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge CLK);
        addr = a;
        wd = d;
        we = 1'b1;
        @(negedge CLK);
        we = 1'b0;
    endtask : wr
    task automatic bw(input logic [2:0] i, input logic v);
        @(negedge CLK);
        addr = timer_pkg::ADDR_T2_CONTROL;
        wd = {7'h00, v};
        bidx = i;
        bwe = 1'b1;
        @(negedge CLK);
        bwe = 1'b0;
    endtask : bw
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge CLK);
        addr = a;
        re = 1'b1;
        @(negedge CLK);
        re = 1'b0;
        chk(rdata, e);
    endtask : rd
    // ==========================================
    // Scenarios
    initial begin
        {RST_N, we, bwe, re, gate0, run0, run1, clr0, clr1, sel0} = '0;
        {addr, wd, bidx, m0, m1} = '0;
        external_interrupt_pin_zero = 1'b1;
        error_cnt = 0;
        checked = 0;
        cyc(20);
        RST_N = 1'b1;
        foreach (t2a[i]) rd(t2a[i], 8'h00);
        wr(8'hc9, 8'h5a);
        rd(8'hc9, 8'h00);
        chk({7'h00, hit}, 8'h00);
        wr(8'hca, 8'hf0);
        wr(8'hcb, 8'hff);
        wr(8'hcc, 8'hfe);
        wr(8'hcd, 8'hff);
        // Three counts across the wrap: fffe, ffff, reload fff0, fff1
        bw(3'h2, 1'b1);
        cyc(1);
        bw(3'h2, 1'b0);
        rd(8'hcc, 8'hf1);
        rd(8'hcd, 8'hff);
        rd(8'hcb, 8'hff);
        rd(8'hc8, 8'h80);
        chk({6'h00, tf2, timer2_external_flag}, 8'h02);
        bw(3'h7, 1'b0);
        rd(8'hc8, 8'h00);
        // Baud mode with capture selected still reloads, without a flag
        wr(8'hcc, 8'hfe);
        wr(8'hc8, 8'h35);
        cyc(1);
        wr(8'hc8, 8'h31);
        rd(8'hcc, 8'hf1);
        rd(8'hc8, 8'h31);
        chk(8'(pins.rx_n), 8'h01);
        chk(8'(pins.tx_n), 8'h01);
        wr(8'hc8, 8'h3b);
        pins.fall(timer_pkg::PIN_TRIG);
        rd(8'hc8, 8'h3b);
        rd(8'hcc, 8'hf1);
        // Counter mode, then capture on the trigger
        wr(8'hc8, 8'h0f);
        pins.fall(timer_pkg::PIN_T2);
        pins.fall(timer_pkg::PIN_T2);
        rd(8'hcc, 8'hf3);
        pins.fall(timer_pkg::PIN_TRIG);
        rd(8'hca, 8'hf3);
        rd(8'hc8, 8'h4f);
        chk({6'h00, tf2, timer2_external_flag}, 8'h01);
        wr(8'hc8, 8'h0e);
        wr(8'hcc, 8'h00);
        pins.fall(timer_pkg::PIN_TRIG);
        rd(8'hcc, 8'hf3);
        rd(8'hc8, 8'h4e);
        wr(8'hc8, 8'h06);
        wr(8'hcc, 8'h00);
        pins.fall(timer_pkg::PIN_TRIG);
        rd(8'hcc, 8'h00);
        rd(8'hc8, 8'h06);
        wr(8'hc8, 8'h00);
        // Timer 0 autoreload: fe, ff, reload 80, 81
        m0 = 2'h2;
        wr(8'h8a, 8'hfe);
        wr(8'h8c, 8'h80);
        run0 = 1'b1;
        cyc(3);
        run0 = 1'b0;
        rd(8'h8a, 8'h81);
        rd(8'h8c, 8'h80);
        chk({7'h00, tf0}, 8'h01);
        {gate0, external_interrupt_pin_zero, run0} = 3'h5;
        cyc(4);
        run0 = 1'b0;
        rd(8'h8a, 8'h81);
        clr0 = 1'b1;
        cyc(1);
        clr0 = 1'b0;
        chk({7'h00, tf0}, 8'h00);
        // Split mode: high byte runs on timer 1 run bit, timer 1 frozen
        // Low byte now counts timer 0 pin falls only, so it stays put until one comes
        {m0, m1, gate0, external_interrupt_pin_zero, sel0, run0} = 8'hf7;
        wr(8'h8c, 8'hfe);
        wr(8'h8b, 8'h10);
        run1 = 1'b1;
        cyc(3);
        run1 = 1'b0;
        rd(8'h8c, 8'h01);
        chk({7'h00, tf1}, 8'h01);
        rd(8'h8b, 8'h10);
        pins.fall(timer_pkg::PIN_T0);
        rd(8'h8a, 8'h82);
        clr1 = 1'b1;
        cyc(1);
        clr1 = 1'b0;
        wr(8'h8d, 8'hf0);
        wr(8'h8b, 8'hfe);
        {m1, run1} = 3'h5;
        cyc(3);
        {m1, run1} = 3'h6;
        rd(8'h8b, 8'hf1);
        chk({7'h00, tf1}, 8'h00);
        chk(8'(pins.rx_n), 8'h02);
        chk(8'(pins.tx_n), 8'h02);
        stop_test();
    end
endmodule : testbench
`default_nettype wire
